// File: hdl/i2m_pkg.sv
// i2m_pkg: constants and types for the two-wire serial memory master
// assumes one 10 MHz system clock; shared by the master and its fifo
package i2m_pkg;

  // system clock and bus rates, in kHz
  localparam int CLK_KHZ      = 10000;
  localparam int SCL_STD_KHZ  = 100;
  localparam int SCL_FAST_KHZ = 400;

  // quarter bit periods, rounded up so the bus never runs too fast
  localparam int QTR_STD  = (CLK_KHZ + 4 * SCL_STD_KHZ - 1) / (4 * SCL_STD_KHZ);
  localparam int QTR_FAST = (CLK_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ);
  localparam int TICK_W   = 5;

  // data path
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int BITS_BYTE  = 9;    // eight data bits plus the ack slot

  // direction bit sent after the target identifier
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  // one transaction request
  typedef struct packed {
    logic       read;     // 1 = read burst, 0 = write burst
    logic [6:0] target;   // seven bit target identifier
    logic [7:0] addr;     // byte address inside the target
    logic [7:0] len_m1;   // number of data bytes minus one
  } i2m_cmd_t;

  // transaction sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDRW, ST_BADDR, ST_RESTART,
    ST_ADDRR, ST_WLOAD, ST_WDATA, ST_RDATA, ST_STOP
  } i2m_state_t;

endpackage

// File: hdl/i2m_fifo.sv
// i2m_fifo: synchronous first-in first-out buffer with valid and ready
// assumes both sides run on the same clock and asynchronous active-low reset copy
`timescale 1ns/1ps
`default_nettype none
module i2m_fifo
  import i2m_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,        // system clock
  input  wire logic             rst_n,      // reset, active low
  input  wire logic             in_valid,   // writer offers a word
  output logic                  in_ready,   // room for a word, registered
  input  wire logic [WIDTH-1:0] in_data,    // word to store
  output logic                  out_valid,  // a word is waiting
  input  wire logic             out_ready,  // reader takes the word
  output logic      [WIDTH-1:0] out_data    // oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0]    count, next_count;
  logic             next_in_ready, push, pop;

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointer and fill level update
  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    next_wr_ptr   = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr   = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count    = count + CW'(push) - CW'(pop);
    next_in_ready = (next_count < CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // i2m_fifo
`default_nettype wire

// File: hdl/i2m_master.sv
// i2m_master: two-wire bus master for reading and writing serial memories
// assumes synchronous inputs on MCLK, pull-ups on both bus lines outside
//
// Behaviour
// - standard 100 kHz or fast 400 kHz clock
// - open-drain or push-pull drive selectable
// - push-pull drives clock; data stays open-drain
// - seven bit target identifier only
// - every transaction opens with start condition
// - identifier, byte address, then data phase
// - all bytes shifted most significant first
// - master acks or nacks each read byte
// - target acks each written byte, sampled
// - single and multi-byte bursts both directions
// - final read byte answered with nack
// - stop condition after last byte
`timescale 1ns/1ps
`default_nettype none
module i2m_master
  import i2m_pkg::*;
(
  input  wire logic              MCLK,           // 10 MHz system clock
  input  wire logic              RESET_N,        // asynchronous reset, active low
  input  wire logic              CFG_FAST,       // 1 = fast speed, 0 = standard
  input  wire logic              CFG_PUSH_PULL,  // 1 = clock line driven both ways
  input  wire logic              CMD_VALID,      // request a transaction
  input  wire i2m_cmd_t          CMD,            // transaction description
  output logic                   CMD_READY,      // idle, request accepted
  input  wire logic              WR_VALID,       // write byte offered
  input  wire logic [DATA_W-1:0] WR_DATA,        // write byte
  output logic                   WR_READY,       // fifo has room
  output logic      [DATA_W-1:0] RD_DATA,        // received byte
  output logic                   RD_VALID,       // received byte pulse
  output logic                   DONE,           // transaction finished pulse
  output logic                   NACK_ERR,       // last transaction refused
  output logic                   BUSY,           // transaction in progress
  output logic                   SCL_O,          // clock line output level
  output logic                   SCL_OE,         // clock line drive enable
  input  wire logic              SDA_I,          // data line level
  output logic                   SDA_O,          // data line output level
  output logic                   SDA_OE          // data line drive enable
);
  // quarter reload values at the counter's width
  localparam logic [TICK_W-1:0] RELOAD_STD  = TICK_W'(QTR_STD - 1);
  localparam logic [TICK_W-1:0] RELOAD_FAST = TICK_W'(QTR_FAST - 1);
  localparam logic [3:0]        LAST_BIT    = 4'(BITS_BYTE - 1);

  // reset release synchroniser
  logic rst_q1, rst_n_s;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_q1  <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1  <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  // write data buffer
  // bytes wait here until the sequencer reaches a data slot;
  // a refused burst leaves its unsent bytes in place
  logic              fifo_valid, fifo_pop;
  logic [DATA_W-1:0] fifo_data;

  i2m_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (MCLK),
    .rst_n     (rst_n_s),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   (WR_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // sequencer state
  i2m_state_t        st, next_st;
  logic [1:0]        q, next_q;
  logic [TICK_W-1:0] cnt, next_cnt;
  logic [3:0]        bitn, next_bitn;
  logic [8:0]        shreg, next_shreg;
  logic [8:0]        rxsh, next_rxsh;
  logic [7:0]        left, next_left;
  i2m_cmd_t          cmd, next_cmd;
  logic              busy, next_busy;
  logic              nack, next_nack;
  logic              done, next_done;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic              rvalid, next_rvalid;
  logic              fast, next_fast;

  logic [TICK_W-1:0] reload;
  logic              tick, last_q, byte_end, ack_in;

  // quarter timing and byte boundary decode
  always_comb begin
    reload   = fast ? RELOAD_FAST : RELOAD_STD;
    tick     = (cnt == '0);
    last_q   = tick && (q == 2'h3);
    byte_end = last_q && (bitn == LAST_BIT);
    ack_in   = rxsh[0];
  end

  // transaction sequencing
  always_comb begin
    next_st     = st;
    next_q      = q;
    next_cnt    = cnt;
    next_bitn   = bitn;
    next_shreg  = shreg;
    next_rxsh   = rxsh;
    next_left   = left;
    next_cmd    = cmd;
    next_busy   = busy;
    next_nack   = nack;
    next_fast   = fast;
    next_done   = 1'b0;
    next_rvalid = 1'b0;
    next_rdata  = rdata;
    fifo_pop    = 1'b0;

    // quarter counter runs whenever the bus is being clocked
    if (st != ST_IDLE && st != ST_WLOAD) begin
      next_cnt = tick ? reload : cnt - 1'b1;
      if (tick) begin
        next_q = q + 1'b1;
      end
    end

    unique case (st)
      // idle: take a request, latch speed and burst length
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_cmd  = CMD;
          next_left = CMD.len_m1;
          next_fast = CFG_FAST;
          next_busy = 1'b1;
          next_nack = 1'b0;
          next_q    = 2'h0;
          next_cnt  = CFG_FAST ? RELOAD_FAST : RELOAD_STD;
          next_st   = ST_START;
        end
      end

      // start or repeated start, then load the identifier
      ST_START, ST_RESTART: begin
        if (last_q) begin
          next_bitn = '0;
          // seven bit identifier and direction, release for ack
          next_shreg = {cmd.target, (st == ST_RESTART) ? DIR_READ : DIR_WRITE,
                        1'b1};
          next_st    = (st == ST_START) ? ST_ADDRW : ST_ADDRR;
        end
      end

      // nine bit slots: eight bits and one ack
      // the ack slot decides whether the burst goes on
      ST_ADDRW, ST_BADDR, ST_ADDRR, ST_WDATA, ST_RDATA: begin
        // sample the line while the clock is high
        if (tick && q == 2'h2) begin
          next_rxsh = {rxsh[7:0], SDA_I};
        end
        if (last_q) begin
          next_shreg = {shreg[7:0], 1'b1};
          next_bitn  = bitn + 1'b1;
        end
        if (byte_end) begin
          next_bitn = '0;
          if (st == ST_RDATA) begin
            next_rdata  = rxsh[8:1];
            next_rvalid = 1'b1;
            if (left == '0) begin
              next_st = ST_STOP;
            end else begin
              next_left  = left - 1'b1;
              next_shreg = {8'hFF, (left == 8'h01)};
            end
          end else if (ack_in) begin
            next_nack = 1'b1;
            next_st   = ST_STOP;
          end else begin
            unique case (st)
              ST_ADDRW: begin
                next_shreg = {cmd.addr, 1'b1};
                next_st    = ST_BADDR;
              end
              ST_BADDR: begin
                next_st = cmd.read ? ST_RESTART : ST_WLOAD;
              end
              ST_ADDRR: begin
                next_shreg = {8'hFF, (left == '0)};
                next_st    = ST_RDATA;
              end
              default: begin
                if (left == '0) begin
                  next_st = ST_STOP;
                end else begin
                  next_left = left - 1'b1;
                  next_st   = ST_WLOAD;
                end
              end
            endcase
          end
        end
      end

      ST_WLOAD: begin
        // clock held low until the next write byte is buffered
        if (fifo_valid) begin
          fifo_pop   = 1'b1;
          next_shreg = {fifo_data, 1'b1};
          next_bitn  = '0;
          next_q     = 2'h0;
          next_cnt   = reload;
          next_st    = ST_WDATA;
        end
      end

      // stop condition, then report completion
      ST_STOP: begin
        if (last_q) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st   = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st     <= ST_IDLE;
      q      <= 2'h0;
      cnt    <= '0;
      bitn   <= '0;
      shreg  <= 9'h1FF;
      rxsh   <= 9'h1FF;
      left   <= '0;
      cmd    <= '0;
      busy   <= 1'b0;
      nack   <= 1'b0;
      done   <= 1'b0;
      rdata  <= '0;
      rvalid <= 1'b0;
      fast   <= 1'b0;
    end else begin
      st     <= next_st;
      q      <= next_q;
      cnt    <= next_cnt;
      bitn   <= next_bitn;
      shreg  <= next_shreg;
      rxsh   <= next_rxsh;
      left   <= next_left;
      cmd    <= next_cmd;
      busy   <= next_busy;
      nack   <= next_nack;
      done   <= next_done;
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
      fast   <= next_fast;
    end
  end

  // bus line levels for the current quarter
  logic scl_high, sda_low;
  logic next_scl_o, next_scl_oe, next_sda_oe;

  always_comb begin
    scl_high = 1'b0;
    sda_low  = 1'b0;
    unique case (st)
      // idle bus: both lines high
      ST_IDLE: begin
        scl_high = 1'b1;
      end
      ST_START, ST_RESTART: begin
        // data falls while the clock is high
        scl_high = (q == 2'h1) || (q == 2'h2);
        sda_low  = q[1];
      end
      // data changes in the low half, clock high in the second half
      // so the line is steady whenever the clock is high
      ST_ADDRW, ST_BADDR, ST_ADDRR, ST_WDATA, ST_RDATA: begin
        scl_high = q[1];
        sda_low  = !shreg[8];
      end
      // clock parked low while the fifo is empty
      ST_WLOAD: begin
        scl_high = 1'b0;
      end
      ST_STOP: begin
        // data rises while the clock is high
        scl_high = (q != 2'h0);
        sda_low  = !q[1];
      end
    endcase
    // push-pull drives the clock both ways, data stays open-drain
    next_scl_oe = CFG_PUSH_PULL ? 1'b1 : !scl_high;
    next_scl_o  = CFG_PUSH_PULL ? scl_high : 1'b0;
    next_sda_oe = sda_low;
  end

  // registered outputs
  // every pin comes from a flop, so the bus lags the state by one clock
  // and no decode glitch ever reaches the lines
  always_ff @(posedge MCLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      SCL_O     <= 1'b0;
      SCL_OE    <= 1'b0;
      SDA_O     <= 1'b0;
      SDA_OE    <= 1'b0;
      CMD_READY <= 1'b0;
      RD_DATA   <= '0;
      RD_VALID  <= 1'b0;
      DONE      <= 1'b0;
      NACK_ERR  <= 1'b0;
      BUSY      <= 1'b0;
    end else begin
      SCL_O     <= next_scl_o;
      SCL_OE    <= next_scl_oe;
      SDA_O     <= 1'b0;
      SDA_OE    <= next_sda_oe;
      CMD_READY <= (next_st == ST_IDLE);
      RD_DATA   <= next_rdata;
      RD_VALID  <= next_rvalid;
      DONE      <= next_done;
      NACK_ERR  <= next_nack;
      BUSY      <= next_busy;
    end
  end
endmodule // i2m_master
`default_nettype wire

// File: bench/i2m_mem_model.sv
// i2m_mem_model: behavioural serial memory on the two-wire bus
// assumes resolved line levels in, pull-up on data, one byte pointer
`timescale 1ns/1ps
`default_nettype none
module i2m_mem_model #(
  parameter logic [6:0] ID = 7'h00   // target identifier, arbitrary
) (
  input  wire logic       scl,       // clock line level
  input  wire logic       sda,       // data line level
  input  wire logic [7:0] nack_at,   // byte index to refuse
  output logic            pull       // 1 pulls data low
);
  logic [7:0] mem [256];
  logic [7:0] sh, ptr, ob, tot;
  logic       rd, rdp, mack;
  int         cnt, nb, acks;
  initial begin
    pull = 1'b0;
    rdp = 1'b0;
    tot = 8'h00;
    cnt = 0;
  end
  // start with clock high restarts byte count
  always @(negedge sda) begin
    #1;
    if (scl) begin
      cnt = 0;
      nb = 0;
      rd = 1'b0;
      rdp = 1'b0;
      acks = 0;
    end
  end
  // stop with clock high ends the transaction
  always @(posedge sda) begin
    #1;
    if (scl) begin
      rdp = 1'b0;
      tot = 8'h00;
      pull = 1'b0;
    end
  end
  // shift in on rising clock, first bit is most significant
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = sda;
    cnt++;
  end
  // ack slot, byte end and read bits on falling clock
  always @(negedge scl) begin
    if (cnt == 8 && !rdp) begin
      if (nb == 0) rd = sh[0];
      else if (nb == 1) ptr = sh;
      else begin
        mem[ptr] = sh;
        ptr++;
      end
      pull = (sh[7:1] == ID || nb != 0) && tot != nack_at;
    end else if (cnt == 8) pull = 1'b0;
    else if (cnt == 9) begin
      if (rdp && !mack) acks++;
      rdp = rd && !(rdp && mack);
      cnt = 0;
      nb++;
      tot++;
      ob = mem[ptr];
      pull = rdp && !ob[7];
      if (rdp) ptr++;
    end else if (rdp && cnt > 0) pull = !ob[7-cnt];
  end
endmodule // i2m_mem_model
`default_nettype wire

// File: bench/i2m_master_asserts.sv
// i2m_master_asserts: port checks of the two-wire memory master
// assumes a bind onto i2m_master, one clock domain on MCLK
`timescale 1ns/1ps
`default_nettype none
module i2m_master_asserts (
  input wire logic MCLK,           // system clock
  input wire logic RESET_N,        // reset, active low
  input wire logic CFG_PUSH_PULL,  // clock drive mode
  input wire logic CMD_VALID,      // request
  input wire logic CMD_READY,      // idle
  input wire logic RD_VALID,       // read byte pulse
  input wire logic DONE,           // end pulse
  input wire logic NACK_ERR,       // refused
  input wire logic BUSY,           // in progress
  input wire logic SCL_O,          // clock level
  input wire logic SCL_OE,         // clock enable
  input wire logic SDA_O,          // data level
  input wire logic SDA_OE          // data enable
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // clock line pulled low
  wire scl_low = SCL_OE && !SCL_O;
  // line drive modes
  a_data_od: assert property (!SDA_O)
    else $error("data line driven high");
  a_clock_pp: assert property (CFG_PUSH_PULL && $past(CFG_PUSH_PULL)
    && $past(CFG_PUSH_PULL, 2) && $past(CMD_READY || BUSY) |-> SCL_OE)
    else $error("clock not driven in push-pull");
  a_clock_od: assert property (!CFG_PUSH_PULL && !$past(CFG_PUSH_PULL)
    && !$past(CFG_PUSH_PULL, 2) |-> !(SCL_OE && SCL_O))
    else $error("clock driven high in open drain");
  // command, completion, idle bus and read spacing
  a_cmd_take: assert property (CMD_VALID && CMD_READY |=>
    BUSY && !CMD_READY && !NACK_ERR) else $error("command not taken");
  a_done_idle: assert property (DONE |-> !BUSY && CMD_READY ##1 !DONE)
    else $error("done not a pulse at idle");
  a_busy_end: assert property ($fell(BUSY) |-> DONE)
    else $error("busy ended without done");
  a_bus_idle: assert property (CMD_READY && $past(CMD_READY)
    |-> !SDA_OE && !scl_low) else $error("bus held while idle");
  a_read_gap: assert property (RD_VALID |=> !RD_VALID [*8])
    else $error("read bytes too close");
  a_nack_hold: assert property (NACK_ERR && !(CMD_VALID && CMD_READY)
    |=> NACK_ERR) else $error("refusal flag lost");
endmodule // i2m_master_asserts
bind i2m_master i2m_master_asserts chk_u (.MCLK(MCLK), .RESET_N(RESET_N),
  .CFG_PUSH_PULL(CFG_PUSH_PULL), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .RD_VALID(RD_VALID), .DONE(DONE), .NACK_ERR(NACK_ERR), .BUSY(BUSY), .SCL_O(SCL_O),
  .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
`default_nettype wire

// File: bench/tb_top.sv
// tb_top: self-checking bench for the two-wire memory master
// assumes the memory model on the bus and pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2m_pkg::*;
  localparam logic [6:0] ID = 7'h2B;  // target identifier, arbitrary
  logic       mclk = 1'b0, rst_n = 1'b0, fast = 1'b0, pp = 1'b0;
  logic       cv = 1'b0, wv = 1'b0, cr, wr, rv, done, nerr, busy;
  logic       scl_o, scl_oe, sda_o, sda_oe, pull;
  logic [7:0] wd = 8'h00, nack_at = 8'hFF, rd;
  i2m_cmd_t   cmd = '0;
  wire        scl_w = scl_oe ? scl_o : 1'b1;
  wire        sda_w = !((sda_oe && !sda_o) || pull);
  int         n_errors = 0, checks_done = 0, nr = 0;
  time        t4, t5;
  logic [7:0] rq [$];
  i2m_master dut_u (.MCLK(mclk), .RESET_N(rst_n), .CFG_FAST(fast), .CFG_PUSH_PULL(pp),
    .CMD_VALID(cv), .CMD(cmd), .CMD_READY(cr), .WR_VALID(wv), .WR_DATA(wd), .WR_READY(wr),
    .RD_DATA(rd), .RD_VALID(rv), .DONE(done), .NACK_ERR(nerr), .BUSY(busy), .SCL_O(scl_o),
    .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe));
  i2m_mem_model #(.ID(ID)) mem_u (.scl(scl_w), .sda(sda_w), .nack_at(nack_at), .pull(pull));
  // clock, read capture and clock line timing
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (rv === 1'b1) rq.push_back(rd);
  always @(posedge scl_w) begin
    nr++;
    if (nr == 4) t4 = $time;
    if (nr == 5) t5 = $time;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic push(input logic [7:0] b);
    int k;
    @(negedge mclk);
    wv = 1'b1;
    wd = b;
    for (k = 0; k < 999 && wr !== 1'b1; k++) @(negedge mclk);
    if (wr !== 1'b1) n_errors++;
    @(negedge mclk);
    wv = 1'b0;
  endtask
  task automatic run(input logic r, input logic [6:0] t, input logic [7:0] a,
                     input logic [7:0] n, input logic ne);
    int k;
    @(negedge mclk);
    rq.delete();
    nr = 0;
    cmd = {r, t, a, n};
    cv = 1'b1;
    for (k = 0; k < 999 && cr !== 1'b1; k++) @(negedge mclk);
    if (cr !== 1'b1) n_errors++;
    @(negedge mclk);
    cv = 1'b0;
    for (k = 0; k < 60000 && done !== 1'b1; k++) @(negedge mclk);
    if (done !== 1'b1) n_errors++;
    chk(nerr, ne);
    chk(busy, 1'b0);
  endtask
  task automatic t_write();
    push(8'hA5);
    push(8'h3C);
    push(8'h81);
    run(1'b0, ID, 8'h10, 8'h02, 1'b0);
    chk(mem_u.mem[8'h10], 8'hA5);
    chk(mem_u.mem[8'h11], 8'h3C);
    chk(mem_u.mem[8'h12], 8'h81);
    chk(16'(t5 - t4), 16'(4 * QTR_STD * 100));
    $display("write test done");
  endtask
  task automatic t_read();
    run(1'b1, ID, 8'h10, 8'h02, 1'b0);
    chk(16'(rq.size()), 16'h0003);
    chk(rq[0], 8'hA5);
    chk(rq[1], 8'h3C);
    chk(rq[2], 8'h81);
    chk(16'(mem_u.acks), 16'h0002);
    chk(mem_u.mack, 1'b1);
    $display("read test done");
  endtask
  task automatic t_fast();
    @(negedge mclk);
    fast = 1'b1;
    pp = 1'b1;
    push(8'h77);
    run(1'b0, ID, 8'hFE, 8'h00, 1'b0);
    chk(mem_u.mem[8'hFE], 8'h77);
    chk(16'(t5 - t4), 16'(4 * QTR_FAST * 100));
    run(1'b1, ID, 8'hFE, 8'h00, 1'b0);
    chk(rq[0], 8'h77);
    chk(mem_u.mack, 1'b1);
    $display("fast push-pull test done");
  endtask
  task automatic t_nack();
    run(1'b0, ID ^ 7'h01, 8'h00, 8'h00, 1'b1);
    nack_at = 8'h02;
    push(8'h11);
    push(8'h22);
    run(1'b0, ID, 8'h30, 8'h01, 1'b1);
    nack_at = 8'hFF;
    run(1'b0, ID, 8'h31, 8'h00, 1'b0);
    chk(mem_u.mem[8'h31], 8'h22);
    $display("refusal test done");
  endtask
  task automatic t_fill();
    @(negedge mclk);
    pp = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) push(8'h40 + 8'(i));
    @(negedge mclk);
    chk(wr, 1'b0);
    run(1'b0, ID, 8'h40, 8'(FIFO_DEPTH - 1), 1'b0);
    chk(wr, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) chk(mem_u.mem[8'h40 + 8'(i)], 8'h40 + 8'(i));
    $display("fifo fill test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    t_write();
    t_read();
    t_fast();
    t_nack();
    t_fill();
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #(100 * 80000);
    n_errors++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
